/* hw/host_request_error_checker.sv */
// Request checker that answers every taken host request with one end code; a datagram request dropped while busy gets none.
// Assumes a parser on clk_sys delivers decoded header fields with valid/ready.
`timescale 1ns/100ps
`include "req_check_params.svh"
module host_request_error_checker
	import req_check_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [15:0] req_cmd,
	input wire logic [15:0] req_sub,
	input wire logic [23:0] req_addr,
	input wire logic [15:0] req_points,
	input wire logic [15:0] req_len_hdr,
	input wire logic [15:0] req_len_act,
	input wire logic req_ascii,
	input wire logic req_conv_err,
	input wire logic req_dev_word,
	input wire logic req_dev_ok,
	input wire logic req_route_ok,
	input wire logic req_bit_data_ok,
	input wire logic req_ext,
	input wire logic req_ext_ok,
	input wire logic req_data_ok,
	input wire logic req_online,
	input wire logic req_udp,
	input wire logic ctrl_err,
	input wire logic [11:0] ctrl_err_code,
	input wire logic online_enable,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [15:0] rsp_code,
	output logic rsp_execute,
	output logic drop_pulse
);

	////////////////////////////////////////////////////////////////////////////
	// Request capture and state.

	chk_state_t state_q;
	logic [15:0] cmd_q, sub_q, pts_q, lenh_q, lena_q;
	logic [23:0] addr_q;
	logic [13:0] flags_q;
	logic [11:0] cerr_q;
	logic mon_reg_q;
	logic [15:0] code_q;
	logic pend_udp_q;
	logic [1:0] buf_cnt_q;
	logic [15:0] buf_code_q [0:1];
	logic buf_exec_q [0:1];
	logic buf_wr_q, buf_rd_q;
	logic buf_full, buf_empty, buf_push, buf_pop;
	logic take;

	// Computes the end code for the captured request by fixed priority.
	function automatic logic [15:0] pick_code(
		input logic [15:0] cmd,
		input logic [15:0] sub,
		input logic [23:0] addr,
		input logic [15:0] pts,
		input logic [15:0] lenh,
		input logic [15:0] lena,
		input logic [13:0] f,
		input logic [11:0] cerr,
		input logic mon_reg,
		input logic online_en
	);
		logic [24:0] end_addr;
		logic known;
		end_addr = {1'b0, addr} + {9'h000, pts};
		known = (cmd == `CMD_READ) || (cmd == `CMD_WRITE) || (cmd == `CMD_MON_REG) || (cmd == `CMD_MON_RUN);
		// Flag order: 0 conv,1 ascii,2 word,3 devok,4 route,5 bitok,6 ext,7 extok,8 dataok,9 online,10 ctrl.
		if (f[10])
			pick_code = `END_CTRL_BASE | {4'h0, cerr};
		else if (f[9] && !online_en)
			pick_code = `END_ONLINE_OFF;
		else if (f[1] && f[0])
			pick_code = `END_ASCII_CONV;
		else if (f[1] && lenh != lena)
			pick_code = `END_LEN_CONV;
		else if (!f[1] && lenh != lena)
			pick_code = `END_LENGTH;
		else if (!known || (sub != `SUB_WORD && sub != `SUB_BIT))
			pick_code = `END_COMMAND;
		else if (!f[4])
			pick_code = `END_NOT_EXEC;
		else if (cmd == `CMD_MON_RUN && !mon_reg)
			pick_code = `END_NO_MONITOR;
		else if (f[6] && !f[7])
			pick_code = `END_EXTENSION;
		else if (!f[3])
			pick_code = `END_NO_ACCESS;
		else if (f[2] && sub == `SUB_BIT)
			pick_code = `END_CONTENT;
		else if (pts < `PTS_MIN)
			pick_code = `END_PTS_LOW;
		else if (sub == `SUB_BIT && pts > `PTS_MAX_BIT)
			pick_code = `END_PTS_HIGH;
		else if (sub == `SUB_WORD && f[2] && pts > `PTS_MAX_WORD)
			pick_code = `END_PTS_WORD;
		else if (sub == `SUB_WORD && !f[2] && pts > `PTS_MAX_WORD)
			pick_code = `END_PTS_WBIT;
		else if (end_addr > {1'b0, `ADDR_LIMIT})
			pick_code = `END_ADDR_RANGE;
		else if (!f[2] && sub == `SUB_BIT && !f[5] && cmd == `CMD_WRITE)
			pick_code = `END_BIT_DATA;
		else if (!f[8])
			pick_code = `END_UNSUPP;
		else
			pick_code = `END_OK;
	endfunction

	// Requests are taken only while idle; a datagram request with a datagram response still in the sequencer is dropped.
	assign req_ready = (state_q == ST_IDLE) || (req_udp && pend_udp_q);
	assign take = req_valid && (state_q == ST_IDLE);

	// Drop indication for datagram requests arriving while a datagram response is still in the sequencer.
	always_ff @(posedge clk_sys) begin
		if (rst)
			drop_pulse <= 1'b0;
		else
			drop_pulse <= req_valid && req_udp && pend_udp_q && (state_q != ST_IDLE);
	end

	// Captures the request fields when taken.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_q <= 16'h0000;
			sub_q <= 16'h0000;
			addr_q <= 24'h000000;
			pts_q <= 16'h0000;
			lenh_q <= 16'h0000;
			lena_q <= 16'h0000;
			flags_q <= 14'h0000;
			cerr_q <= 12'h000;
		end else if (take) begin
			cmd_q <= req_cmd;
			sub_q <= req_sub;
			addr_q <= req_addr;
			pts_q <= req_points;
			lenh_q <= req_len_hdr;
			lena_q <= req_len_act;
			flags_q <= {2'b00, req_udp, ctrl_err, req_online, req_data_ok, req_ext_ok, req_ext, req_bit_data_ok,
				req_route_ok, req_dev_ok, req_dev_word, req_ascii, req_conv_err};
			cerr_q <= 12'(ctrl_err_code & `END_CTRL_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	// Moves from capture to check to handing the answer into the buffer.
	always_ff @(posedge clk_sys) begin
		if (rst)
			state_q <= ST_IDLE;
		else begin
			case (state_q)
				ST_IDLE: begin
					if (take)
						state_q <= ST_CHECK;
				end
				ST_CHECK: state_q <= ST_SEND;
				ST_SEND: begin
					if (!buf_full)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Holds the single chosen end code for the request.
	always_ff @(posedge clk_sys) begin
		if (rst)
			code_q <= `END_OK;
		else if (state_q == ST_CHECK)
			code_q <= pick_code(cmd_q, sub_q, addr_q, pts_q, lenh_q, lena_q, flags_q, cerr_q,
				mon_reg_q, online_enable);
	end

	// Remembers a successful monitor registration.
	always_ff @(posedge clk_sys) begin
		if (rst)
			mon_reg_q <= 1'b0;
		else if (buf_push && cmd_q == `CMD_MON_REG && code_q == `END_OK)
			mon_reg_q <= 1'b1;
	end

	// Marks a datagram response not yet handed into the buffer.
	// The mark lives from the take through the first idle cycle; drops also need req_udp, so a stream request is never dropped.
	always_ff @(posedge clk_sys) begin
		if (rst)
			pend_udp_q <= 1'b0;
		else if (take)
			pend_udp_q <= req_udp;
		else if (state_q == ST_IDLE)
			pend_udp_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-entry response buffer.

	assign buf_full = (buf_cnt_q == 2'd2);
	assign buf_empty = (buf_cnt_q == 2'd0);
	assign buf_push = (state_q == ST_SEND) && !buf_full;
	assign buf_pop = rsp_ready && !buf_empty;
	assign rsp_valid = !buf_empty;

	// Stores answers so a stalled receiver loses none.
	// One-bit pointers wrap by toggling; the count alone tells full from empty.
	// The sequencer waits in its send state while both entries are taken.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buf_cnt_q <= 2'd0;
			buf_wr_q <= 1'b0;
			buf_rd_q <= 1'b0;
			buf_code_q[0] <= `END_OK;
			buf_code_q[1] <= `END_OK;
			buf_exec_q[0] <= 1'b0;
			buf_exec_q[1] <= 1'b0;
		end else begin
			if (buf_push) begin
				buf_code_q[buf_wr_q] <= code_q;
				buf_exec_q[buf_wr_q] <= (code_q == `END_OK);
				buf_wr_q <= !buf_wr_q;
			end
			if (buf_pop)
				buf_rd_q <= !buf_rd_q;
			buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// Head-of-buffer data outputs.
	// They look one entry ahead on a pop, so the next code stands right after the pop edge.
	// A freshly filled empty buffer shows its code one cycle after the valid rises.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_code <= `END_OK;
			rsp_execute <= 1'b0;
		end else begin
			rsp_code <= buf_code_q[buf_rd_q ^ buf_pop];
			rsp_execute <= buf_exec_q[buf_rd_q ^ buf_pop];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_check_send;
		state_q == ST_CHECK ##1 state_q == ST_SEND;
	endsequence

	a_take_to_check: assert property (@(posedge clk_sys) disable iff (rst) take |=> state_q == ST_CHECK)
		else $error("taken request did not enter check");
	a_online_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && flags_q[9] && !online_enable && !flags_q[10]) |=> code_q == `END_ONLINE_OFF)
		else $error("online change code wrong");
	a_ctrl_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && flags_q[10]) |=> code_q[15:12] == 4'h4)
		else $error("controller error code out of range");
	a_conv_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && !flags_q[10] && !flags_q[9] && flags_q[1] && flags_q[0]) |=> code_q == `END_ASCII_CONV)
		else $error("conversion code wrong");
	a_len_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && !flags_q[10] && !flags_q[9] && !flags_q[1] && lenh_q != lena_q)
		|=> code_q == `END_LENGTH)
		else $error("length code wrong");
	a_exec_flag: assert property (@(posedge clk_sys) disable iff (rst)
		buf_push |=> buf_exec_q[$past(buf_wr_q)] == (code_q == `END_OK))
		else $error("execute flag disagrees with code");
	a_udp_drop: assert property (@(posedge clk_sys) disable iff (rst)
		(req_valid && req_udp && pend_udp_q && state_q != ST_IDLE) |=> drop_pulse)
		else $error("pending datagram request not dropped");
	a_check_seq: assert property (@(posedge clk_sys) disable iff (rst)
		s_check_send |-> ##[0:4] state_q == ST_IDLE || buf_full)
		else $error("answer not handed on");
	a_buf_bound: assert property (@(posedge clk_sys) disable iff (rst) buf_cnt_q <= 2'd2)
		else $error("response buffer overrun");

	// A finished answer with room in the buffer is offered on the next cycle.
	sequence s_send_free;
		state_q == ST_SEND ##0 !buf_full;
	endsequence

	// An offered answer that the host has not taken yet.
	sequence s_rsp_stalled;
		rsp_valid ##0 !rsp_ready;
	endsequence

	// A monitor registration that was answered without error.
	sequence s_mon_ok_push;
		buf_push ##0 cmd_q == `CMD_MON_REG ##0 code_q == `END_OK;
	endsequence

	a_send_offer: assert property (@(posedge clk_sys) disable iff (rst) s_send_free |=> rsp_valid)
		else $error("answer not offered");
	a_rsp_hold: assert property (@(posedge clk_sys) disable iff (rst) s_rsp_stalled |=> rsp_valid)
		else $error("stalled answer withdrawn");
	a_mon_sticky: assert property (@(posedge clk_sys) disable iff (rst) s_mon_ok_push |=> mon_reg_q)
		else $error("monitor registration lost");
	a_ctrl_low: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && flags_q[10]) |=> code_q[11:0] == cerr_q)
		else $error("controller error detail lost");
	a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q != ST_IDLE && !(req_udp && pend_udp_q)) |-> !req_ready)
		else $error("request accepted while busy");
	a_cmd_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && !flags_q[10] && !flags_q[9] && !flags_q[0] && lenh_q == lena_q
		&& sub_q != `SUB_WORD && sub_q != `SUB_BIT) |=> code_q == `END_COMMAND)
		else $error("command code wrong");
	a_route_code: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_CHECK && !flags_q[10] && !flags_q[9] && !flags_q[0] && lenh_q == lena_q
		&& cmd_q == `CMD_READ && sub_q == `SUB_WORD && !flags_q[4]) |=> code_q == `END_NOT_EXEC)
		else $error("routing code wrong");

endmodule

/* hw/req_check_params.svh */
// Constants for the host request checker: end codes, limits and layout.
// Assumes inclusion by bare name from the package and design files.
`ifndef REQ_CHECK_PARAMS_SVH
`define REQ_CHECK_PARAMS_SVH
`define END_OK 16'h0000
`define END_ONLINE_OFF 16'h0055
`define END_ASCII_CONV 16'hc050
`define END_PTS_LOW 16'hc051
`define END_PTS_HIGH 16'hc052
`define END_PTS_WBIT 16'hc053
`define END_PTS_WORD 16'hc054
`define END_ADDR_RANGE 16'hc056
`define END_LEN_CONV 16'hc058
`define END_COMMAND 16'hc059
`define END_NO_ACCESS 16'hc05b
`define END_CONTENT 16'hc05c
`define END_NO_MONITOR 16'hc05d
`define END_NOT_EXEC 16'hc05f
`define END_BIT_DATA 16'hc060
`define END_LENGTH 16'hc061
`define END_EXTENSION 16'hc070
`define END_UNSUPP 16'hc0b5
`define END_CTRL_BASE 16'h4000
`define END_CTRL_MASK 16'h0fff
`define PTS_MIN 16'h0001
`define PTS_MAX_WORD 16'h03c0
`define PTS_MAX_BIT 16'h0f00
`define ADDR_LIMIT 24'h004000
`define CMD_READ 16'h0401
`define CMD_WRITE 16'h1401
`define CMD_MON_REG 16'h0801
`define CMD_MON_RUN 16'h0802
`define SUB_WORD 16'h0000
`define SUB_BIT 16'h0001
`endif

/* hw/req_check_pkg.sv */
// Types for the host request checker.
// Assumes the constants header sits beside it.
`include "req_check_params.svh"
package req_check_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CHECK = 3'b010,
		ST_SEND = 3'b100
	} chk_state_t;
endpackage

/* tb/host_sink.sv */
// Host-side model that takes end codes off the checker's response port.
// Assumes the clk_sys domain and the one-cycle code lag behind rsp_valid.
`timescale 1ns/100ps
module host_sink (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic stall,
	input wire logic rsp_valid,
	output logic rsp_ready,
	input wire logic [15:0] rsp_code,
	input wire logic rsp_execute,
	output logic got,
	output logic [15:0] got_code,
	output logic got_exec
);
	logic wait_q;
	// Accepts one response at a time, a cycle after the code has settled, and may stall.
	always_ff @(posedge clk_sys) begin
		got <= 1'b0;
		if (rst) begin
			rsp_ready <= 1'b0;
			wait_q <= 1'b0;
		end else if (rsp_valid && rsp_ready) begin
			got <= 1'b1;
			got_code <= rsp_code;
			got_exec <= rsp_execute;
			rsp_ready <= 1'b0;
			wait_q <= 1'b0;
		end else if (rsp_valid) begin
			wait_q <= 1'b1;
			rsp_ready <= wait_q && !stall;
		end
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the host request checker.
// Assumes the host_sink model drains responses; inputs change at falling edges.
`timescale 1ns/100ps
module tb;
	import req_check_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, stall = 1'b0;
	logic [15:0] req_cmd, req_sub, req_points, req_len_hdr, req_len_act, rsp_code, got_code;
	logic [23:0] req_addr;
	logic req_ascii, req_conv_err, req_dev_word, req_dev_ok, req_route_ok, req_bit_data_ok;
	logic req_ext, req_ext_ok, req_data_ok, req_online, req_udp, ctrl_err, online_enable;
	logic [11:0] ctrl_err_code;
	logic rsp_valid, rsp_ready, rsp_execute, drop_pulse, got, got_exec;
	int errors = 0, check_count = 0;
	logic [15:0] exp_q[$];
	host_request_error_checker dut (.*);
	host_sink sink (.clk_sys, .rst, .stall, .rsp_valid, .rsp_ready, .rsp_code, .rsp_execute,
		.got, .got_code, .got_exec);
	// Clock at 40 MHz.
	always #12.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] a, input logic [15:0] e);
		check_count++;
		if (a !== e) begin
			errors++;
			$display("[ERR] %0t code %h expected %h", $time, a, e);
		end
	endtask
	task automatic chk1(input logic a, input logic e);
		check_count++;
		if (a !== e) begin
			errors++;
			$display("[ERR] %0t flag %b expected %b", $time, a, e);
		end
	endtask
	task automatic hang(input string s);
		errors++;
		$display("[ERR] %0t %s timed out", $time, s);
		results();
	endtask
	// Sets up a well-formed word read.
	task automatic clear();
		{req_cmd, req_sub, req_addr, req_points} = {16'h0401, 16'h0000, 24'h000000, 16'h0001};
		{req_len_hdr, req_len_act, ctrl_err_code} = {16'h000c, 16'h000c, 12'h000};
		{req_ascii, req_conv_err, req_ext, req_online, req_udp, ctrl_err} = 6'h00;
		{req_dev_word, req_dev_ok, req_route_ok, req_bit_data_ok, req_ext_ok} = 5'h1f;
		{req_data_ok, online_enable} = 2'h3;
	endtask
	task automatic push(input logic [15:0] code);
		int n = 0;
		while (req_ready !== 1'b1) begin
			@(negedge clk_sys);
			if (++n > 60) hang("take");
		end
		exp_q.push_back(code);
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask
	task automatic pull();
		int n = 0;
		logic [15:0] e;
		while (got !== 1'b1) begin
			@(negedge clk_sys);
			if (++n > 200) hang("response");
		end
		e = exp_q.pop_front();
		chk16(got_code, e);
		chk1(got_exec, e == 16'h0000);
		@(negedge clk_sys);
	endtask
	task automatic run(input logic [15:0] code);
		push(code);
		pull();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_fmt();
		clear();
		run(16'h0000);
		req_ascii = 1'b1;
		req_conv_err = 1'b1;
		run(16'hc050);
		req_conv_err = 1'b0;
		req_len_act = 16'h000d;
		run(16'hc058);
		req_ascii = 1'b0;
		run(16'hc061);
		clear();
		req_cmd = 16'h0402;
		run(16'hc059);
		$display("test fmt done");
	endtask
	task automatic t_dev();
		clear();
		req_route_ok = 1'b0;
		run(16'hc05f);
		clear();
		req_dev_ok = 1'b0;
		run(16'hc05b);
		clear();
		req_sub = 16'h0001;
		run(16'hc05c);
		clear();
		{req_ext, req_ext_ok} = 2'h2;
		run(16'hc070);
		clear();
		req_data_ok = 1'b0;
		run(16'hc0b5);
		clear();
		{req_cmd, req_sub, req_dev_word, req_bit_data_ok} = {16'h1401, 16'h0001, 2'h0};
		run(16'hc060);
		$display("test dev done");
	endtask
	task automatic t_pts();
		clear();
		req_points = 16'h0000;
		run(16'hc051);
		req_points = 16'h03c0;
		run(16'h0000);
		req_points = 16'h03c1;
		run(16'hc054);
		req_dev_word = 1'b0;
		run(16'hc053);
		{req_sub, req_points} = {16'h0001, 16'h0f00};
		run(16'h0000);
		req_points = 16'h0f01;
		run(16'hc052);
		clear();
		req_addr = 24'h003fff;
		run(16'h0000);
		req_points = 16'h0002;
		run(16'hc056);
		$display("test pts done");
	endtask
	task automatic t_mon();
		clear();
		req_cmd = 16'h0802;
		run(16'hc05d);
		req_cmd = 16'h0801;
		run(16'h0000);
		req_cmd = 16'h0802;
		run(16'h0000);
		$display("test mon done");
	endtask
	task automatic t_prio();
		clear();
		{req_online, online_enable} = 2'h2;
		run(16'h0055);
		online_enable = 1'b1;
		run(16'h0000);
		{ctrl_err, ctrl_err_code, online_enable} = {1'b1, 12'h123, 1'b0};
		run(16'h4123);
		clear();
		{req_ascii, req_conv_err, req_cmd} = {2'h3, 16'h0402};
		run(16'hc050);
		$display("test prio done");
	endtask
	task automatic t_buf();
		clear();
		stall = 1'b1;
		push(16'h0000);
		req_cmd = 16'h0402;
		push(16'hc059);
		clear();
		req_dev_ok = 1'b0;
		push(16'hc05b);
		repeat (8) @(negedge clk_sys);
		chk1(req_ready, 1'b0);
		stall = 1'b0;
		repeat (3) pull();
		$display("test buf done");
	endtask
	task automatic t_udp();
		clear();
		req_udp = 1'b1;
		push(16'h0000);
		@(negedge clk_sys);
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		chk1(drop_pulse, 1'b1);
		pull();
		repeat (10) @(negedge clk_sys);
		chk1(rsp_valid, 1'b0);
		$display("test udp done");
	endtask
	// Main sequence: reset, then every scenario in turn.
	initial begin
		clear();
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		t_fmt();
		t_dev();
		t_pts();
		t_mon();
		t_prio();
		t_buf();
		t_udp();
		results();
	end
endmodule
